// file: ssr_pkg.sv
// ****************************************************************
// shared constants and carriers
// ****************************************************************
package ssr_pkg;

  // chain length and output latency in rising edges
  localparam int unsigned STAGES     = 8;
  localparam int unsigned LAST_STAGE = STAGES - 1;

  // output buffer geometry
  localparam int unsigned BUF_DEPTH  = 2;

  // probe counter width used by the latency checks
  localparam int unsigned PROBE_W    = 4;
  localparam logic [3:0]  PROBE_IDLE = 4'h0;
  localparam logic [3:0]  PROBE_ONE  = 4'h1;
  localparam logic [3:0]  PROBE_DONE = 4'h8;

  // occupancy of the two-entry buffer
  typedef enum logic [1:0]
  {
    SSR_BUF_EMPTY = 2'b00,
    SSR_BUF_ONE   = 2'b01,
    SSR_BUF_TWO   = 2'b10
  } ssr_fill_e;

  // output level pair, true and complement
  typedef struct packed
  {
    logic level;
    logic level_n;
  } ssr_level_s;

  localparam int unsigned LEVEL_W = $bits(ssr_level_s);

endpackage

// file: ssr_out_buf.sv
`timescale 1ns/100ps
// ****************************************************************
// two-entry buffer, valid/ready on both sides
// ****************************************************************
module ssr_out_buf
#(
  parameter int unsigned WIDTH = ssr_pkg::LEVEL_W
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0]  mem_q [ssr_pkg::BUF_DEPTH];
  logic              wr_ptr_q;
  logic              rd_ptr_q;
  ssr_pkg::ssr_fill_e fill_q;
  logic              push;
  logic              pop;

  assign in_ready  = (fill_q != ssr_pkg::SSR_BUF_TWO);
  assign out_valid = (fill_q != ssr_pkg::SSR_BUF_EMPTY);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q];

  // storage carries no reset, only the pointers and fill state do
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
      begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      fill_q <= ssr_pkg::SSR_BUF_EMPTY;
    end
    else
    begin
      unique case (fill_q)
        ssr_pkg::SSR_BUF_EMPTY:
        begin
          if (push)
          begin
            fill_q <= ssr_pkg::SSR_BUF_ONE;
          end
        end
        ssr_pkg::SSR_BUF_ONE:
        begin
          if (push && !pop)
          begin
            fill_q <= ssr_pkg::SSR_BUF_TWO;
          end
          else if (pop && !push)
          begin
            fill_q <= ssr_pkg::SSR_BUF_EMPTY;
          end
        end
        ssr_pkg::SSR_BUF_TWO:
        begin
          if (pop)
          begin
            fill_q <= ssr_pkg::SSR_BUF_ONE;
          end
        end
        default:
        begin
          fill_q <= ssr_pkg::SSR_BUF_EMPTY;
        end
      endcase
    end
  end

endmodule

// file: ssr_shift8.sv
`timescale 1ns/100ps
// ****************************************************************
// serial-in serial-out shift chain
// ****************************************************************
// Summary of operation
// - eight stages clocked together; serial in at first, only last stage visible
// - each rising shift clock edge moves bits forward and loads first stage
// - first stage loads the AND of both gate inputs
// - level formed while clock low appears after exactly eight rising edges, plus complement
module ssr_shift8
#(
  parameter int unsigned STAGES = ssr_pkg::STAGES
)
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // serial gate inputs and shift clock pin
  input  wire logic         gate_a,
  input  wire logic         gate_b,
  input  wire logic         shift_clk,
  // last stage outputs
  output logic              q_true,
  output logic              q_comp,
  // stream of shifted-out levels
  output logic              bit_valid,
  input  wire logic         bit_ready,
  output ssr_pkg::ssr_level_s bit_data,
  // back-pressure and drop flag toward the source
  output logic              shift_ready,
  output logic              overflow
);

  // ****************************************************************
  // input gating and edge detection
  // ****************************************************************
  function automatic logic gate_and(input logic a, input logic b);
    gate_and = a & b;
  endfunction

  logic              clk_prev_q;
  logic              gated_low_q;
  logic              shift;
  logic              load_bit;
  logic [STAGES-1:0] chain_q;
  logic              comp_q;
  logic              push_ready;
  ssr_pkg::ssr_level_s push_data;

  assign shift    = shift_clk && !clk_prev_q;
  assign load_bit = gated_low_q;

  // previous pin level, to find the low-to-high transition
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      clk_prev_q <= 1'b1;
    end
    else
    begin
      clk_prev_q <= shift_clk;
    end
  end

  // and of gates
  // sampled only while the pin is low so the edge uses the level seen while clock was low
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      gated_low_q <= 1'b0;
    end
    else if (!shift_clk)
    begin
      gated_low_q <= gate_and(gate_a, gate_b);
    end
  end

  // ****************************************************************
  // shift chain
  // ****************************************************************
  // eight stage chain
  // no reset here
  // chain is data, not control; leaving it unreset mirrors the part
  always_ff @(posedge clock)
  begin
    if (shift)
    begin
      chain_q <= {chain_q[STAGES-2:0], load_bit};
    end
  end

  // complement flop
  // separate flop so both outputs come from registers and switch together
  always_ff @(posedge clock)
  begin
    if (shift)
    begin
      comp_q <= ~chain_q[STAGES-2];
    end
  end

  assign q_true = chain_q[STAGES-1];
  assign q_comp = comp_q;

  // ****************************************************************
  // output stream through the buffer
  // ****************************************************************
  // the pin clock cannot be stalled, so a push into a full buffer drops
  assign push_data.level   = chain_q[STAGES-2];
  assign push_data.level_n = ~chain_q[STAGES-2];
  assign shift_ready       = push_ready;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      overflow <= 1'b0;
    end
    else
    begin
      overflow <= shift && !push_ready;
    end
  end

  ssr_out_buf
  #(
    .WIDTH (ssr_pkg::LEVEL_W)
  )
  u_out_buf
  (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (shift),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (bit_valid),
    .out_ready (bit_ready),
    .out_data  (bit_data)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [ssr_pkg::PROBE_W-1:0] probe_cnt_q;
  logic                        probe_bit_q;

  // one bit at a time is followed through the chain
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      probe_cnt_q <= ssr_pkg::PROBE_IDLE;
      probe_bit_q <= 1'b0;
    end
    else if (shift)
    begin
      if (probe_cnt_q == ssr_pkg::PROBE_IDLE || probe_cnt_q == ssr_pkg::PROBE_DONE)
      begin
        probe_cnt_q <= ssr_pkg::PROBE_ONE;
        probe_bit_q <= load_bit;
      end
      else
      begin
        probe_cnt_q <= probe_cnt_q + ssr_pkg::PROBE_ONE;
      end
    end
  end

  property p_latency;
    @(posedge clock) disable iff (reset)
    (probe_cnt_q == ssr_pkg::PROBE_DONE) |-> (q_true == probe_bit_q) && (q_comp == !probe_bit_q);
  endproperty
  a_latency: assert property (p_latency) else $error("output does not match bit loaded eight edges ago");

  property p_gate_zero;
    @(posedge clock) disable iff (reset)
    (!shift_clk && !(gate_a && gate_b)) ##1 shift |=> !chain_q[0];
  endproperty
  a_gate_zero: assert property (p_gate_zero) else $error("low gate input did not load a zero");

  property p_gate_one;
    @(posedge clock) disable iff (reset)
    (!shift_clk && gate_a && gate_b) ##1 shift |=> chain_q[0];
  endproperty
  a_gate_one: assert property (p_gate_one) else $error("both gates high did not load a one");

  property p_advance;
    @(posedge clock) disable iff (reset)
    shift |=> chain_q[STAGES-1:1] === $past(chain_q[STAGES-2:0]);
  endproperty
  a_advance: assert property (p_advance) else $error("chain did not advance on rising edge");

  property p_hold;
    @(posedge clock) disable iff (reset)
    !shift |=> (chain_q === $past(chain_q)) && (q_comp === $past(q_comp));
  endproperty
  a_hold: assert property (p_hold) else $error("chain moved without a rising edge");

  property p_no_clear;
    @(posedge clock) disable iff (reset)
    $fell(reset) && !shift |-> chain_q === $past(chain_q);
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("reset altered the chain");

  property p_overflow;
    @(posedge clock) disable iff (reset)
    shift && !push_ready |=> overflow;
  endproperty
  a_overflow: assert property (p_overflow) else $error("dropped level not flagged");

  // stream word matches last stage
  // checked from an empty buffer only, where the new word becomes the head
  property p_stream;
    @(posedge clock) disable iff (reset)
    shift && push_ready && !bit_valid |=> bit_valid && (bit_data === {q_true, q_comp});
  endproperty
  a_stream: assert property (p_stream) else $error("stream word does not match last stage");

  property p_stream_hold;
    @(posedge clock) disable iff (reset)
    bit_valid && !bit_ready |=> bit_valid && (bit_data === $past(bit_data));
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stalled stream word changed");

endmodule

// file: ssr_src_model.sv
`timescale 1ns/100ps
// ****************************************************************
// source logic and receiver outside the chain
// ****************************************************************
module ssr_src_model
(
  // clock
  input  wire logic clock,
  // receiver control
  input  wire logic stall,
  // gate inputs and shift clock pin
  output logic      gate_a,
  output logic      gate_b,
  output logic      shift_clk,
  // receiver handshake
  output logic      bit_ready
);
  initial
  begin
    gate_a    = 1'b0;
    gate_b    = 1'b0;
    shift_clk = 1'b0;
    bit_ready = 1'b1;
  end

  always @(negedge clock)
  begin
    bit_ready <= !stall;
  end

  task automatic push_bit(input logic a, input logic b);
    @(negedge clock);
    gate_a    = a;
    gate_b    = b;
    shift_clk = 1'b0;
    @(negedge clock);
    // rising pin edge
    // gates flip while high, so only the low-phase level may count
    shift_clk = 1'b1;
    gate_a    = !a;
    gate_b    = !b;
    repeat (2) @(negedge clock);
  endtask
endmodule

// file: ssr_shift8_tb_top.sv
`timescale 1ns/100ps
module ssr_shift8_tb_top;
  typedef struct packed
  {
    logic a;
    logic b;
    logic q;
  } ssr_row_s;

  localparam ssr_row_s ROWS [0:7] = '{3'h7, 3'h2, 3'h4, 3'h0, 3'h7, 3'h7, 3'h4, 3'h7};

  logic                clock = 1'b0;
  logic                reset = 1'b1;
  logic                stall = 1'b0;
  logic                gate_a;
  logic                gate_b;
  logic                shift_clk;
  logic                q_true;
  logic                q_comp;
  logic                bit_valid;
  logic                bit_ready;
  ssr_pkg::ssr_level_s bit_data;
  logic                shift_ready;
  logic                overflow;
  int                  n_errors = 0;
  int                  checks_done = 0;
  int                  n_ovf = 0;
  int                  n_shift = 0;
  logic                exp_q [$];
  logic                sexp [$];
  logic                hold;

  always #20 clock = ~clock;

  ssr_shift8 dut_u (.clock(clock), .reset(reset), .gate_a(gate_a), .gate_b(gate_b), .shift_clk(shift_clk),
    .q_true(q_true), .q_comp(q_comp), .bit_valid(bit_valid), .bit_ready(bit_ready), .bit_data(bit_data),
    .shift_ready(shift_ready), .overflow(overflow));

  ssr_src_model src_u (.clock(clock), .stall(stall), .gate_a(gate_a), .gate_b(gate_b), .shift_clk(shift_clk),
    .bit_ready(bit_ready));

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [1:0] got, input logic [1:0] want);
    checks_done++;
    if (got !== want)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
      n_errors++;
    end
  endtask

  // drop marks a word the full buffer must lose
  task automatic shift(input logic a, input logic b, input logic q, input logic drop);
    logic e;
    exp_q.push_back(q);
    n_shift++;
    e = (n_shift >= 8) ? exp_q[n_shift-8] : 1'bx;
    if (!drop)
      sexp.push_back(e);
    src_u.push_bit(a, b);
    if (n_shift >= 8)
      check({q_true, q_comp}, {e, !e});
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (sexp.size() != 0 && k < 20)
    begin
      @(negedge clock);
      k++;
    end
    if (sexp.size() != 0)
    begin
      n_errors++;
      finish_test();
    end
  endtask

  // ****************************************************************
  // stream monitor
  // ****************************************************************
  always @(posedge clock)
  begin
    if (overflow === 1'b1)
      n_ovf++;
    if (bit_valid === 1'b1 && bit_ready === 1'b1)
    begin
      if (sexp.size() == 0)
        check(2'h3, 2'h0);
      else if (sexp[0] !== 1'bx)
        check(bit_data, {sexp[0], !sexp[0]});
      if (sexp.size() != 0)
        void'(sexp.pop_front());
    end
  end

  initial
  begin
    repeat (3) @(negedge clock);
    reset = 1'b0;
    // two passes, checked from the eighth shift
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 8; i++)
        shift(ROWS[i].a, ROWS[i].b, ROWS[i].q, 1'b0);
    drain();
    // receiver stalls: two words held, third dropped, chain still shifts
    stall = 1'b1;
    shift(1'b1, 1'b1, 1'b1, 1'b0);
    shift(1'b0, 1'b1, 1'b0, 1'b0);
    check({1'b0, shift_ready}, 2'h0);
    check(n_ovf[1:0], 2'h0);
    shift(1'b1, 1'b1, 1'b1, 1'b1);
    check(n_ovf[1:0], 2'h1);
    stall = 1'b0;
    drain();
    hold = q_true;
    reset = 1'b1;
    @(negedge clock);
    check({bit_valid, shift_ready}, 2'h1);
    check({overflow, q_true}, {1'b0, hold});
    reset = 1'b0;
    shift(1'b0, 1'b0, 1'b0, 1'b0);
    shift(1'b1, 1'b1, 1'b1, 1'b0);
    drain();
    finish_test();
  end
endmodule
